// file: logic/gpp_pkg.sv
package gpp_pkg;

  // register indices on the plain port (word addresses)
  localparam logic [3:0] GPP_ADDR_PINS = 4'h0;
  localparam logic [3:0] GPP_ADDR_LATCH = 4'h1;
  localparam logic [3:0] GPP_ADDR_DIR = 4'h2;
  localparam logic [3:0] GPP_ADDR_ANALOG = 4'h3;
  localparam logic [3:0] GPP_ADDR_PERIPH = 4'h4;

  // reset values: all pins inputs, analog on, no peripheral
  localparam logic [7:0] GPP_RST_LATCH = 8'h00;
  localparam logic [7:0] GPP_RST_DIR = 8'hFF;
  localparam logic [7:0] GPP_RST_ANALOG = 8'hFF;
  localparam logic [7:0] GPP_RST_PERIPH = 8'h00;

  localparam int GPP_WIDTH = 8;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpp_bus_req_t;

  typedef struct packed {
    logic [7:0] in;
    logic [7:0] out;
    logic [7:0] oe;
  } gpp_pad_t;

endpackage

// file: logic/gpp_sync.sv
`timescale 1ns/100ps
module gpp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gpp_sync_state_t;

  gpp_sync_state_t state_r;
  gpp_sync_state_t state_nxt;

  // first stage feeds only the second
  always_comb begin
    state_nxt = state_r;
    state_nxt.stage1 = async_i;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_o = state_r.stage2;

endmodule

// file: logic/gpp_pad_mux.sv
`timescale 1ns/100ps
module gpp_pad_mux #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] latch_i,
  input wire logic [WIDTH-1:0] dir_i,
  input wire logic [WIDTH-1:0] periph_en_i,
  input wire logic [WIDTH-1:0] periph_out_i,
  input wire logic [WIDTH-1:0] periph_oe_i,
  output logic [WIDTH-1:0] pad_out_o,
  output logic [WIDTH-1:0] pad_oe_o
);

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (periph_en_i[i]) begin
        pad_out_o[i] = periph_out_i[i];
        pad_oe_o[i] = periph_oe_i[i];
      end else begin
        pad_out_o[i] = latch_i[i];
        pad_oe_o[i] = ~dir_i[i];
      end
    end
  end

endmodule

// file: logic/gpp_port.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module gpp_port #(
  parameter int WIDTH = gpp_pkg::GPP_WIDTH
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [WIDTH-1:0] pad_in_i,
  output logic [WIDTH-1:0] pad_out_o,
  output logic [WIDTH-1:0] pad_oe_o,
  output logic [WIDTH-1:0] periph_in_o,
  input wire logic [WIDTH-1:0] periph_out_i,
  input wire logic [WIDTH-1:0] periph_oe_i
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] analog;
    logic [WIDTH-1:0] periph_en;
    logic [WIDTH-1:0] pad_out;
    logic [WIDTH-1:0] pad_oe;
    logic [WIDTH-1:0] periph_in;
    logic [7:0] rdata;
  } gpp_state_t;

  gpp_state_t state_r;
  gpp_state_t state_nxt;
  gpp_pkg::gpp_bus_req_t req;
  logic [WIDTH-1:0] pins_sync;
  logic [WIDTH-1:0] digital_in;
  logic [WIDTH-1:0] mux_out;
  logic [WIDTH-1:0] mux_oe;

  function automatic logic [7:0] gpp_widen(input logic [WIDTH-1:0] v);
    logic [7:0] w;
    w = '0;
    for (int i = 0; i < WIDTH && i < 8; i++) begin
      w[i] = v[i];
    end
    return w;
  endfunction

  function automatic logic [WIDTH-1:0] gpp_narrow(input logic [7:0] v);
    logic [WIDTH-1:0] n;
    n = '0;
    for (int i = 0; i < WIDTH && i < 8; i++) begin
      n[i] = v[i];
    end
    return n;
  endfunction

  assign req.addr = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr = wr_i;
  assign req.rd = rd_i;

  ////////////////////////////////////////////////////////////////////////////
  // pins are asynchronous to mclk, so resample before any use
  gpp_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(pad_in_i),
    .sync_o(pins_sync)
  );

  // analog pins read zero, saving input buffer toggling
  assign digital_in = pins_sync & ~state_r.analog;

  gpp_pad_mux #(
    .WIDTH(WIDTH)
  ) u_mux (
    .latch_i(state_r.latch),
    .dir_i(state_r.dir),
    .periph_en_i(state_r.periph_en),
    .periph_out_i(periph_out_i),
    .periph_oe_i(periph_oe_i),
    .pad_out_o(mux_out),
    .pad_oe_o(mux_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        gpp_pkg::GPP_ADDR_PINS,
        gpp_pkg::GPP_ADDR_LATCH: state_nxt.latch = gpp_narrow(req.wdata);
        gpp_pkg::GPP_ADDR_DIR: state_nxt.dir = gpp_narrow(req.wdata);
        gpp_pkg::GPP_ADDR_ANALOG: state_nxt.analog = gpp_narrow(req.wdata);
        gpp_pkg::GPP_ADDR_PERIPH: state_nxt.periph_en = gpp_narrow(req.wdata);
        default: state_nxt.latch = state_r.latch;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        gpp_pkg::GPP_ADDR_PINS: state_nxt.rdata = gpp_widen(digital_in);
        gpp_pkg::GPP_ADDR_LATCH: state_nxt.rdata = gpp_widen(state_r.latch);
        gpp_pkg::GPP_ADDR_DIR: state_nxt.rdata = gpp_widen(state_r.dir);
        gpp_pkg::GPP_ADDR_ANALOG: state_nxt.rdata = gpp_widen(state_r.analog);
        gpp_pkg::GPP_ADDR_PERIPH: state_nxt.rdata = gpp_widen(state_r.periph_en);
        default: state_nxt.rdata = 8'h00;
      endcase
    end
    // pad drive registered so outputs come from flops; one cycle of lag
    state_nxt.pad_out = mux_out;
    state_nxt.pad_oe = mux_oe;
    state_nxt.periph_in = digital_in;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r.latch <= gpp_narrow(gpp_pkg::GPP_RST_LATCH);
      state_r.dir <= gpp_narrow(gpp_pkg::GPP_RST_DIR);
      state_r.analog <= gpp_narrow(gpp_pkg::GPP_RST_ANALOG);
      state_r.periph_en <= gpp_narrow(gpp_pkg::GPP_RST_PERIPH);
      state_r.pad_out <= '0;
      state_r.pad_oe <= '0;
      state_r.periph_in <= '0;
      state_r.rdata <= 8'h00;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o = state_r.rdata;
  assign pad_out_o = state_r.pad_out;
  assign pad_oe_o = state_r.pad_oe;
  assign periph_in_o = state_r.periph_in;

endmodule

// file: testbench/gpp_ext_model.sv
`timescale 1ns/100ps
// far side: pin shows device drive where enabled, else external level
module gpp_ext_model (
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_o
);
  assign pin_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_val_i);
endmodule

// file: testbench/gpp_port_sva.sv
`timescale 1ns/100ps
module gpp_port_chk #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [WIDTH-1:0] pad_in_i,
  input wire logic [WIDTH-1:0] pad_out_o,
  input wire logic [WIDTH-1:0] pad_oe_o,
  input wire logic [WIDTH-1:0] periph_in_o,
  input wire logic [WIDTH-1:0] periph_out_i,
  input wire logic [WIDTH-1:0] periph_oe_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
  // write, one idle cycle, then read back: the bench tasks leave that gap
  a_pin_wr: assert property (wr_i && addr_i == 4'h0 ##1 !wr_i ##1 rd_i && addr_i == 4'h1
    |=> rdata_o == $past(wdata_i, 3)) else $error("pin view write missed latch");
  a_latch_rd: assert property (wr_i && addr_i == 4'h1 ##1 !wr_i ##1 rd_i && addr_i == 4'h1
    |=> rdata_o == $past(wdata_i, 3)) else $error("latch readback wrong");
  // a bit read as one must be high on the pin; analog pins may read zero
  a_pin_rd: assert property ($stable(pad_in_i)[*4] ##0 rd_i && addr_i == 4'h0
    |=> rdata_o == periph_in_o && (rdata_o & ~$past(pad_in_i)) == 8'h00) else $error("pin view read wrong");
  a_ana_off: assert property (wr_i && addr_i == 4'h3 ##1 !wr_i
    |=> (periph_in_o & $past(wdata_i, 2)) == 8'h00) else $error("analog pin input live");
  a_dir_in: assert property (wr_i && addr_i == 4'h2 ##1 !wr_i
    |=> (pad_oe_o & $past(wdata_i, 2) & ~$past(periph_oe_i)) == 8'h00) else $error("input pin driven");
  a_per_own: assert property (wr_i && addr_i == 4'h4 ##1 !wr_i
    |=> ((pad_oe_o ^ $past(periph_oe_i)) & $past(wdata_i, 2)) == 8'h00) else $error("peripheral lost pin");
endmodule
bind gpp_port gpp_port_chk #(.WIDTH(WIDTH)) u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .periph_in_o(periph_in_o), .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i));

// file: testbench/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) \
  cmp_count++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); \
  end
module tb;
  logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, pad_in_i, pad_out_o, pad_oe_o, periph_in_o, q;
  logic [7:0] p_out = 0, p_oe = 0, ext = 8'h9A;
  int errors = 0, cmp_count = 0;
  // rows: write index, write data, read index, expected read
  logic [23:0] rows [5] = '{24'h0A51A5, 24'h13C13C, 24'h238238, 24'h300300, 24'h755700};
  always #12.5 mclk_i = ~mclk_i;
  gpp_port dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .periph_in_o(periph_in_o), .periph_out_i(p_out), .periph_oe_i(p_oe));
  gpp_ext_model u_ext (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_val_i(ext), .pin_o(pad_in_i));
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  task results;
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][23:20], rows[i][19:12]);
      rd(rows[i][11:8]);
      `CHK(q, rows[i][7:0])
    end
    repeat (4) @(posedge mclk_i);
    #1;
    `CHK(pad_oe_o, 8'hC7)
    `CHK(pad_out_o & pad_oe_o, 8'h04)
    rd(gpp_pkg::GPP_ADDR_PINS);
    `CHK(q, 8'h1C)
    `CHK(periph_in_o, 8'h1C)
    @(posedge mclk_i);
    ext <= 8'h62;
    // two sync stages: first read still sees the old level
    rd(gpp_pkg::GPP_ADDR_PINS);
    `CHK(q, 8'h1C)
    rd(gpp_pkg::GPP_ADDR_PINS);
    `CHK(q, 8'h24)
    wr(gpp_pkg::GPP_ADDR_ANALOG, 8'hFF);
    repeat (3) @(posedge mclk_i);
    rd(gpp_pkg::GPP_ADDR_PINS);
    `CHK(q, 8'h00)
    `CHK(periph_in_o, 8'h00)
    @(posedge mclk_i);
    p_out <= 8'hA5;
    p_oe <= 8'h0F;
    wr(gpp_pkg::GPP_ADDR_PERIPH, 8'h0F);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK(pad_oe_o, 8'hCF)
    `CHK(pad_out_o & 8'h0F, 8'h05)
    rd(gpp_pkg::GPP_ADDR_PERIPH);
    `CHK(q, 8'h0F)
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK(pad_oe_o, 8'h00)
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(gpp_pkg::GPP_ADDR_LATCH);
    `CHK(q, gpp_pkg::GPP_RST_LATCH)
    rd(gpp_pkg::GPP_ADDR_DIR);
    `CHK(q, gpp_pkg::GPP_RST_DIR)
    results();
  end
endmodule
